//--- core/iab_pkg.sv
/*
  shared constants, types and register map of the integer alu and branch unit.
  assumes a single 200 MHz clock and an ahb-lite master that only makes word transfers.
*/
package iab_pkg;
  // ******************************************************************
  // register map (byte addresses, low address byte only)
  // ******************************************************************
  localparam logic [7:0] ADDR_INSTR = 8'h00;
  localparam logic [7:0] ADDR_PC = 8'h04;
  localparam logic [7:0] ADDR_NPC = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0c;
  localparam logic [7:0] ADDR_RES = 8'h10;
  localparam logic [7:0] ADDR_RSEL = 8'h14;
  localparam logic [7:0] ADDR_RDAT = 8'h18;
  localparam logic [7:0] ADDR_Y = 8'h1c;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  // ******************************************************************
  // instruction encoding
  // ******************************************************************
  localparam logic [1:0] FMT_BRANCH = 2'h0;
  localparam logic [1:0] FMT_SET_UPPER = 2'h1;
  localparam logic [1:0] FMT_ALU = 2'h2;
  localparam logic [1:0] FMT_CTL = 2'h3;
  localparam logic [1:0] BK_INT = 2'h0;
  localparam logic [1:0] BK_FLOAT = 2'h1;
  localparam logic [1:0] BK_COPROC = 2'h2;
  localparam logic [4:0] OP_ADD = 5'h00;
  localparam logic [4:0] OP_ADD_CARRY = 5'h01;
  localparam logic [4:0] OP_SUB = 5'h02;
  localparam logic [4:0] OP_SUB_CARRY = 5'h03;
  localparam logic [4:0] OP_AND = 5'h04;
  localparam logic [4:0] OP_AND_NOT = 5'h05;
  localparam logic [4:0] OP_OR = 5'h06;
  localparam logic [4:0] OP_OR_NOT = 5'h07;
  localparam logic [4:0] OP_XOR = 5'h08;
  localparam logic [4:0] OP_XNOR = 5'h09;
  localparam logic [4:0] OP_SHL = 5'h0a;
  localparam logic [4:0] OP_SHR = 5'h0b;
  localparam logic [4:0] OP_SHRA = 5'h0c;
  localparam logic [4:0] OP_TAG_ADD = 5'h0d;
  localparam logic [4:0] OP_TAG_SUB = 5'h0e;
  localparam logic [4:0] OP_TAG_ADD_TRAP = 5'h0f;
  localparam logic [4:0] OP_TAG_SUB_TRAP = 5'h10;
  localparam logic [4:0] OP_MUL_STEP = 5'h11;
  localparam logic [4:0] OP_JUMP_LINK = 5'h00;
  localparam logic [4:0] OP_TRAP_RETURN = 5'h01;
  localparam logic [4:0] OP_COND_TRAP = 5'h02;
  localparam logic [4:0] OP_WIN_SAVE = 5'h03;
  localparam logic [4:0] OP_WIN_RESTORE = 5'h04;
  // per low cond code: which of the four external cc values pass
  localparam logic [31:0] CC_MASK = {4'b1000, 4'b0100, 4'b1100, 4'b0010,
                                     4'b1010, 4'b0110, 4'b1110, 4'b0000};
  // ******************************************************************
  // timing and values
  // ******************************************************************
  localparam logic [1:0] LAST_ONE = 2'h0;
  localparam logic [1:0] LAST_TWO = 2'h1;
  localparam logic [1:0] LAST_FOUR = 2'h3;
  localparam logic [31:0] PC_STEP = 32'h4;
  localparam logic [31:0] RESET_PC = 32'h0;
  localparam logic [7:0] TT_SOFT_BASE = 8'h80;
  localparam logic [7:0] TT_TAG_OVF = 8'h0a;
  localparam logic [31:0] ZERO_WORD = 32'h0;
  typedef enum logic {ST_IDLE, ST_EXEC} iab_state_e;
  typedef struct packed {logic n; logic z; logic v; logic c;} iab_icc_s;
  typedef struct packed {
    logic [1:0] fmt; logic [4:0] rd; logic [5:0] op6;
    logic [4:0] rs1; logic imm_sel; logic [12:0] short_signed_immediate;
  } iab_instr_s;
  typedef struct packed {
    logic [1:0] fmt; logic annul; logic [3:0] cond;
    logic rsvd; logic [1:0] kind; logic [21:0] disp;
  } iab_br_s;
  typedef struct packed {
    logic [15:0] rsvd_hi; logic [7:0] tt; logic rsvd; logic busy;
    logic annul; logic trap; iab_icc_s icc;
  } iab_stat_s;
endpackage : iab_pkg

//--- core/iab_alu_branch_unit.sv
/*
  integer execution and branch resolution unit with its register file, behind ahb-lite.
  assumes one slave on the bus, word transfers only, and external cc inputs synchronous.
*/
// Design decisions made here: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module iab_alu_branch_unit
  import iab_pkg::*;
(
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  input wire logic [1:0] FCC_I,
  input wire logic FCC_VALID_I,
  input wire logic [1:0] CCC_I,
  input wire logic CCC_VALID_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  output logic TRAP_O
);
  // ******************************************************************
  // state
  // ******************************************************************
  iab_state_e state_reg;
  logic [1:0] cnt_reg;
  logic [31:0] instr_reg, pc_reg, npc_reg, y_reg, res_reg, hrdata_reg;
  logic [31:0] rf [1:31];
  logic [4:0] rsel_reg;
  logic [7:0] tt_reg, dph_addr_reg;
  iab_icc_s icc_reg;
  logic trap_reg, annul_reg, dph_valid_reg, dph_write_reg, hreadyout_reg, hresp_reg;
  iab_instr_s ins;
  iab_br_s br;
  assign ins = instr_reg;
  assign br = instr_reg;

  function automatic logic [32:0] add33(input logic [31:0] a, input logic [31:0] b,
                                        input logic cin);
    add33 = {1'b0, a} + {1'b0, b} + {32'h0, cin};
  endfunction : add33

  function automatic logic cc_test(input logic [3:0] cond, input logic [1:0] cc);
    cc_test = cond[3] ^ CC_MASK[{cond[2:0], cc}];
  endfunction : cc_test

  function automatic logic icc_test(input logic [3:0] cond, input iab_icc_s f);
    logic base;
    base = 1'b0;
    unique case (cond[2:0])
      3'h0: base = 1'b0;
      3'h1: base = f.z;
      3'h2: base = f.z | (f.n ^ f.v);
      3'h3: base = f.n ^ f.v;
      3'h4: base = f.c | f.z;
      3'h5: base = f.c;
      3'h6: base = f.n;
      3'h7: base = f.v;
    endcase
    icc_test = cond[3] ^ base;
  endfunction : icc_test

  function automatic logic [31:0] rf_rd(input logic [4:0] idx);
    rf_rd = (idx == 5'h0) ? ZERO_WORD : rf[idx];
  endfunction : rf_rd

  // ******************************************************************
  // operands and execution
  // ******************************************************************
  logic [31:0] op1, op2, add_a, add_b, res, disp_ext;
  logic [32:0] sum;
  logic [4:0] op5;
  logic [1:0] need;
  iab_icc_s new_cc;
  logic is_alu, is_ctl, is_br, is_sub, cc_wr, rd_wr, tag_v, tag_trap, ovf, carry;
  logic br_taken, ext_wait, ticc_tk, jump, retire, annul_set;
  assign op5 = ins.op6[4:0];
  assign is_alu = ins.fmt == FMT_ALU;
  assign is_ctl = ins.fmt == FMT_CTL;
  assign is_br = ins.fmt == FMT_BRANCH;
  assign op1 = rf_rd(ins.rs1);
  assign op2 = ins.imm_sel ? {{19{ins.short_signed_immediate[12]}}, ins.short_signed_immediate} : rf_rd(ins.short_signed_immediate[4:0]);
  assign is_sub = is_alu && (op5 == OP_SUB || op5 == OP_SUB_CARRY || op5 == OP_TAG_SUB ||
                             op5 == OP_TAG_SUB_TRAP);
  // multiply step shifts (n xor v) into op1 and adds op2 only when y lsb is set
  assign add_a = (is_alu && op5 == OP_MUL_STEP) ? {icc_reg.n ^ icc_reg.v, op1[31:1]} : op1;
  assign add_b = (is_alu && op5 == OP_MUL_STEP && !y_reg[0]) ? ZERO_WORD :
                 (is_sub ? ~op2 : op2);
  always_comb
  begin
    logic cin;
    cin = 1'b0;
    if (is_alu && op5 == OP_ADD_CARRY)
      cin = icc_reg.c;
    else if (is_alu && op5 == OP_SUB_CARRY)
      cin = ~icc_reg.c;
    else if (is_sub)
      cin = 1'b1;
    sum = add33(add_a, add_b, cin);
  end
  assign ovf = (add_a[31] == add_b[31]) && (sum[31] != add_a[31]);
  assign carry = is_sub ? ~sum[32] : sum[32];
  assign ticc_tk = is_ctl && op5 == OP_COND_TRAP && icc_test(ins.rd[3:0], icc_reg);

  always_comb
  begin
    res = ZERO_WORD;
    cc_wr = 1'b0;
    rd_wr = 1'b0;
    tag_v = 1'b0;
    new_cc = icc_reg;
    new_cc.v = 1'b0;
    new_cc.c = 1'b0;
    if (ins.fmt == FMT_SET_UPPER)
    begin
      res = {instr_reg[21:0], 10'h000};
      rd_wr = 1'b1;
    end
    else if (is_alu)
    begin
      rd_wr = 1'b1;
      cc_wr = ins.op6[5];
      unique case (op5)
        OP_ADD, OP_ADD_CARRY, OP_SUB, OP_SUB_CARRY:
        begin
          res = sum[31:0];
          new_cc.v = ovf;
          new_cc.c = carry;
        end
        OP_TAG_ADD, OP_TAG_SUB, OP_TAG_ADD_TRAP, OP_TAG_SUB_TRAP:
        begin
          res = sum[31:0];
          tag_v = ovf | (|op1[1:0]) | (|op2[1:0]);
          new_cc.v = tag_v;
          new_cc.c = carry;
          cc_wr = 1'b1;
          // a trapping variant leaves its destination untouched when it traps
          if ((op5 == OP_TAG_ADD_TRAP || op5 == OP_TAG_SUB_TRAP) && tag_v)
            rd_wr = 1'b0;
        end
        OP_MUL_STEP:
        begin
          res = sum[31:0];
          new_cc.v = ovf;
          new_cc.c = carry;
          cc_wr = 1'b1;
        end
        OP_AND: res = op1 & op2;
        OP_AND_NOT: res = op1 & ~op2;
        OP_OR: res = op1 | op2;
        OP_OR_NOT: res = op1 | ~op2;
        OP_XOR: res = op1 ^ op2;
        OP_XNOR: res = ~(op1 ^ op2);
        OP_SHL: {cc_wr, res} = {1'b0, op1 << op2[4:0]};
        OP_SHR: {cc_wr, res} = {1'b0, op1 >> op2[4:0]};
        OP_SHRA: {cc_wr, res} = {1'b0, 32'($signed(op1) >>> op2[4:0])};
        default: {cc_wr, rd_wr} = 2'b00;
      endcase
    end
    else if (is_ctl)
    begin
      rd_wr = op5 == OP_JUMP_LINK || op5 == OP_WIN_SAVE || op5 == OP_WIN_RESTORE;
      res = (op5 == OP_JUMP_LINK) ? pc_reg : sum[31:0];
    end
    new_cc.n = res[31];
    new_cc.z = res == ZERO_WORD;
  end
  assign tag_trap = is_alu && (op5 == OP_TAG_ADD_TRAP || op5 == OP_TAG_SUB_TRAP) && tag_v;

  // ******************************************************************
  // branch resolution and cycle count
  // ******************************************************************
  assign disp_ext = {{8{br.disp[21]}}, br.disp, 2'b00};
  // never and always need no cc, so they do not wait on the external unit
  assign ext_wait = is_br && br.cond[2:0] != 3'h0 &&
                    ((br.kind == BK_FLOAT && !FCC_VALID_I) ||
                     (br.kind == BK_COPROC && !CCC_VALID_I));
  always_comb
  begin
    unique case (br.kind)
      BK_INT: br_taken = icc_test(br.cond, icc_reg);
      BK_FLOAT: br_taken = cc_test(br.cond, FCC_I);
      BK_COPROC: br_taken = cc_test(br.cond, CCC_I);
      default: br_taken = 1'b0;
    endcase
    br_taken = br_taken && is_br;
  end
  assign jump = is_ctl && (op5 == OP_JUMP_LINK || op5 == OP_TRAP_RETURN);
  assign need = jump ? LAST_TWO : (ticc_tk ? LAST_FOUR : LAST_ONE);
  assign retire = state_reg == ST_EXEC && cnt_reg == need && !ext_wait;
  assign annul_set = is_br && !br_taken && br.annul;

  // ******************************************************************
  // ahb-lite slave
  // ******************************************************************
  logic acc, bus_wr, issue;
  iab_stat_s stat, wstat;
  assign acc = HSEL_I && HTRANS_I[1] && HREADY_I;
  assign bus_wr = dph_valid_reg && dph_write_reg && hreadyout_reg;
  assign issue = bus_wr && dph_addr_reg == ADDR_INSTR;
  assign wstat = HWDATA_I;
  always_comb
  begin
    stat = '0;
    stat.tt = tt_reg;
    stat.busy = state_reg == ST_EXEC;
    stat.annul = annul_reg;
    stat.trap = trap_reg;
    stat.icc = icc_reg;
  end
  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RST_N_I)
    begin
      dph_valid_reg <= 1'b0;
      dph_write_reg <= 1'b0;
      dph_addr_reg <= 8'h00;
      hreadyout_reg <= 1'b1;
      hresp_reg <= 1'b0;
      hrdata_reg <= ZERO_WORD;
    end
    else
    begin
      if (HREADY_I)
      begin
        dph_valid_reg <= acc && HSIZE_I == HSIZE_WORD;
        dph_write_reg <= HWRITE_I;
        dph_addr_reg <= HADDR_I[7:0];
      end
      // an instruction write waits until the previous one has retired
      if (acc && HWRITE_I && HADDR_I[7:0] == ADDR_INSTR)
        hreadyout_reg <= 1'b0;
      else if (!hreadyout_reg && state_reg == ST_IDLE)
        hreadyout_reg <= 1'b1;
      if (acc && !HWRITE_I)
      begin
        unique case (HADDR_I[7:0])
          ADDR_INSTR: hrdata_reg <= instr_reg;
          ADDR_PC: hrdata_reg <= pc_reg;
          ADDR_NPC: hrdata_reg <= npc_reg;
          ADDR_STAT: hrdata_reg <= stat;
          ADDR_RES: hrdata_reg <= res_reg;
          ADDR_RSEL: hrdata_reg <= {27'h0, rsel_reg};
          ADDR_RDAT: hrdata_reg <= rf_rd(rsel_reg);
          ADDR_Y: hrdata_reg <= y_reg;
          default: hrdata_reg <= ZERO_WORD;
        endcase
      end
    end
  end
  assign HRDATA_O = hrdata_reg;
  assign HREADYOUT_O = hreadyout_reg;
  assign HRESP_O = hresp_reg;
  assign TRAP_O = trap_reg;

  // ******************************************************************
  // sequencing
  // ******************************************************************
  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RST_N_I)
    begin
      state_reg <= ST_IDLE;
      cnt_reg <= 2'h0;
      instr_reg <= ZERO_WORD;
    end
    else if (issue && !annul_reg)
    begin
      state_reg <= ST_EXEC;
      cnt_reg <= 2'h0;
      instr_reg <= HWDATA_I;
    end
    else if (state_reg == ST_EXEC)
    begin
      if (retire)
        state_reg <= ST_IDLE;
      else if (!ext_wait)
        cnt_reg <= cnt_reg + 2'h1;
    end
  end

  // the target only lands in npc, so the delay slot runs first unless an untaken annulling branch skips it
  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RST_N_I)
    begin
      pc_reg <= RESET_PC;
      npc_reg <= RESET_PC + PC_STEP;
      annul_reg <= 1'b0;
    end
    else if (bus_wr && dph_addr_reg == ADDR_PC)
    begin
      pc_reg <= HWDATA_I;
      npc_reg <= HWDATA_I + PC_STEP;
    end
    else if (issue && annul_reg)
    begin
      pc_reg <= npc_reg;
      npc_reg <= npc_reg + PC_STEP;
      annul_reg <= 1'b0;
    end
    else if (retire)
    begin
      pc_reg <= npc_reg;
      if (br_taken)
        npc_reg <= pc_reg + PC_STEP + disp_ext;
      else if (jump)
        npc_reg <= sum[31:0];
      else
        npc_reg <= npc_reg + PC_STEP;
      annul_reg <= annul_set;
    end
  end

  always_ff @(posedge CORE_CLK_I)
  begin
    if (bus_wr && dph_addr_reg == ADDR_RDAT && rsel_reg != 5'h0)
      rf[rsel_reg] <= HWDATA_I;
    if (retire && rd_wr && ins.rd != 5'h0)
      rf[ins.rd] <= res;
  end

  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RST_N_I)
    begin
      res_reg <= ZERO_WORD;
      y_reg <= ZERO_WORD;
      rsel_reg <= 5'h00;
    end
    else
    begin
      if (bus_wr && dph_addr_reg == ADDR_RSEL)
        rsel_reg <= HWDATA_I[4:0];
      if (bus_wr && dph_addr_reg == ADDR_Y)
        y_reg <= HWDATA_I;
      else if (retire && is_alu && op5 == OP_MUL_STEP)
        y_reg <= {op1[0], y_reg[31:1]};
      if (retire)
        res_reg <= res;
    end
  end

  // hardware trap events win over a software clear in the same cycle
  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RST_N_I)
    begin
      icc_reg <= '0;
      trap_reg <= 1'b0;
      tt_reg <= 8'h00;
    end
    else
    begin
      if (bus_wr && dph_addr_reg == ADDR_STAT)
      begin
        icc_reg <= wstat.icc;
        if (wstat.trap)
          trap_reg <= 1'b0;
      end
      if (retire && cc_wr)
        icc_reg <= new_cc;
      if (retire && tag_trap)
      begin
        trap_reg <= 1'b1;
        tt_reg <= TT_TAG_OVF;
      end
      else if (retire && ticc_tk)
      begin
        trap_reg <= 1'b1;
        tt_reg <= TT_SOFT_BASE + {1'b0, sum[6:0]};
      end
    end
  end

  // ******************************************************************
  // assertions
  // ******************************************************************
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);
  iab_instr_s win;
  assign win = HWDATA_I;
  sequence s_retire_then_idle;
    retire ##1 (state_reg == ST_IDLE);
  endsequence
  sequence s_two_step;
    !retire ##1 retire;
  endsequence
  property p_one_cycle;
    issue && !annul_reg && win.fmt == FMT_ALU |=> s_retire_then_idle;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("alu op not one cycle");
  property p_jump_two;
    issue && !annul_reg && win.fmt == FMT_CTL && win.op6[4:0] == OP_JUMP_LINK |=> s_two_step;
  endproperty
  a_jump_two: assert property (p_jump_two) else $error("jump not two cycles");
  property p_trap_four;
    state_reg == ST_EXEC && cnt_reg == 2'h0 && ticc_tk |-> (!retire)[*3] ##1 retire;
  endproperty
  a_trap_four: assert property (p_trap_four) else $error("taken trap not four cycles");
  property p_set_upper;
    retire && ins.fmt == FMT_SET_UPPER |=> res_reg[9:0] == 10'h000 &&
      res_reg[31:10] == $past(instr_reg[21:0]);
  endproperty
  a_set_upper: assert property (p_set_upper) else $error("set upper wrong");
  property p_reg_zero;
    acc && !HWRITE_I && HADDR_I[7:0] == ADDR_RDAT && rsel_reg == 5'h0 |=> hrdata_reg == ZERO_WORD;
  endproperty
  a_reg_zero: assert property (p_reg_zero) else $error("register zero not zero");
  property p_tag_trap;
    retire && tag_trap |=> trap_reg && tt_reg == TT_TAG_OVF && icc_reg.v;
  endproperty
  a_tag_trap: assert property (p_tag_trap) else $error("tagged trap missed");
  property p_target;
    retire && br_taken && br.kind == BK_INT |=> npc_reg == $past(pc_reg) + PC_STEP +
      $past(disp_ext);
  endproperty
  a_target: assert property (p_target) else $error("branch target wrong");
  property p_annul;
    retire && is_br |=> annul_reg == $past(annul_set) ##1 !(issue && annul_reg) or
      (annul_reg == $past(annul_set));
  endproperty
  a_annul: assert property (p_annul) else $error("annul flag wrong");
  property p_flags_hold;
    !(retire && cc_wr) && !(bus_wr && dph_addr_reg == ADDR_STAT) |=> $stable(icc_reg);
  endproperty
  a_flags_hold: assert property (p_flags_hold) else $error("flags changed");
  property p_ext_wait;
    state_reg == ST_EXEC && ext_wait |=> state_reg == ST_EXEC && cnt_reg == $past(cnt_reg);
  endproperty
  a_ext_wait: assert property (p_ext_wait) else $error("retired without cc");
endmodule : iab_alu_branch_unit
`default_nettype wire

//--- tb/iab_cc_partner.sv
/*
  far-side condition-code source, standing for the float unit or the coprocessor.
  assumes load_i is a one-cycle pulse driven just after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module iab_cc_partner
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic load_i,
  input wire logic [1:0] val_i,
  input wire logic [3:0] lat_i,
  output logic [1:0] cc_o,
  output logic valid_o
);
  logic [3:0] cnt_reg;
  // codes churn while not valid, so a stale value never passes for an answer
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      cnt_reg <= 4'h0;
      valid_o <= 1'b0;
      cc_o <= 2'h0;
    end
    else if (load_i)
    begin
      cnt_reg <= lat_i;
      valid_o <= 1'b0;
      cc_o <= ~cc_o;
    end
    else if (cnt_reg != 4'h0)
    begin
      cnt_reg <= cnt_reg - 4'h1;
      cc_o <= ~cc_o;
    end
    else
    begin
      valid_o <= 1'b1;
      cc_o <= val_i;
    end
  end
endmodule : iab_cc_partner
`default_nettype wire

//--- tb/iab_alu_branch_unit_bench.sv
/*
  self-checking bench: ahb-lite master, two cc partners, queued read checker.
  assumes the unit is the only slave and its hreadyout is the bus hready.
*/
`timescale 1ns/1ps
`default_nettype none
module iab_alu_branch_unit_bench
  import iab_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, rd_pend = 1'b0;
  logic fld = 1'b0, hready, hresp, trap, fvld, cvld;
  logic [1:0] htrans = 2'h0, fval = 2'h0, fcc, ccc;
  logic [3:0] lat = 4'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, a, b, s;
  logic [31:0] expq[$];
  int n_errors = 0, checks_done = 0;
  always #2.5 clk = ~clk;
  iab_alu_branch_unit dut (.CORE_CLK_I(clk), .RST_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(HSIZE_WORD), .HWDATA_I(hwdata),
    .HREADY_I(hready), .FCC_I(fcc), .FCC_VALID_I(fvld), .CCC_I(ccc), .CCC_VALID_I(cvld),
    .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp), .TRAP_O(trap));
  iab_cc_partner fpu (.clk_i(clk), .rst_n_i(rst_n), .load_i(fld), .val_i(fval),
    .lat_i(lat), .cc_o(fcc), .valid_o(fvld));
  iab_cc_partner cop (.clk_i(clk), .rst_n_i(rst_n), .load_i(fld), .val_i(fval),
    .lat_i(lat), .cc_o(ccc), .valid_o(cvld));
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  function automatic logic [31:0] alu_w(input logic [4:0] d, input logic sc,
    input logic [4:0] op, input logic [4:0] r1, input logic im, input logic [12:0] v);
    return {FMT_ALU, d, sc, op, r1, im, v};
  endfunction : alu_w
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge clk);
    while (hready !== 1'b1)
    begin
      @(posedge clk);
      n++;
      if (n > 500)
      begin
        n_errors++;
        wrap_up();
      end
    end
  endtask : wait_rdy
  // address phase held until hready, then data phase held until hready
  task automatic xfer(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, ad};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_pend <= ~wr;
    wait_rdy();
    rd_pend <= 1'b0;
  endtask : xfer
  task automatic rd(input logic [7:0] ad, input logic [31:0] e);
    expq.push_back(e);
    xfer(1'b0, ad, 32'h0);
  endtask : rd
  task automatic issue(input logic [31:0] w);
    xfer(1'b1, ADDR_INSTR, w);
    repeat (4) @(posedge clk);
  endtask : issue
  // looks one edge later so a flag written by the last transfer has settled
  task automatic chk_trap(input logic e);
    @(posedge clk);
    checks_done++;
    if (trap !== e)
    begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, trap, e);
    end
  endtask : chk_trap
  task automatic setr(input logic [4:0] i, input logic [31:0] v);
    xfer(1'b1, ADDR_RSEL, {27'h0, i});
    xfer(1'b1, ADDR_RDAT, v);
  endtask : setr
  always @(posedge clk)
  begin
    if (rd_pend && hready === 1'b1)
    begin
      checks_done++;
      if (hrdata !== expq[0])
      begin
        n_errors++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, hrdata, expq[0]);
      end
      void'(expq.pop_front());
      if (hresp !== 1'b0)
      begin
        n_errors++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, hresp, 1'b0);
      end
    end
  end
  // ******************************************************************
  // main sequence
  // ******************************************************************
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd(ADDR_PC, RESET_PC);
    rd(ADDR_NPC, PC_STEP);
    a = xs(32'h7937);
    b = xs(a);
    s = a + b;
    setr(5'h1, a);
    setr(5'h2, b);
    issue(alu_w(5'h3, 1'b0, OP_ADD, 5'h1, 1'b0, 13'h2));
    rd(ADDR_RES, s);
    rd(ADDR_STAT, 32'h0);
    issue(alu_w(5'h0, 1'b1, OP_ADD, 5'h1, 1'b0, 13'h2));
    rd(ADDR_STAT, {28'h0, s[31], s == 32'h0, a[31] == b[31] && s[31] != a[31], s < a});
    xfer(1'b1, ADDR_RSEL, 32'h0);
    rd(ADDR_RDAT, 32'h0);
    issue(alu_w(5'h4, 1'b0, OP_ADD, 5'h1, 1'b1, 13'h1ffc));
    rd(ADDR_RES, a - 32'h4);
    issue(alu_w(5'h5, 1'b0, OP_SHL, 5'h1, 1'b1, 13'h0023));
    rd(ADDR_RES, a << 3);
    issue(alu_w(5'h9, 1'b0, OP_SHRA, 5'h1, 1'b1, 13'h0024));
    rd(ADDR_RES, 32'($signed(a) >>> 4));
    s = a - b;
    issue(alu_w(5'h0, 1'b1, OP_SUB, 5'h1, 1'b0, 13'h2));
    rd(ADDR_STAT, {28'h0, s[31], s == 32'h0, a[31] != b[31] && s[31] != a[31], a < b});
    issue(alu_w(5'h6, 1'b1, OP_XOR, 5'h1, 1'b0, 13'h1));
    rd(ADDR_STAT, 32'h4);
    issue({FMT_SET_UPPER, 5'h7, 3'h0, 22'h2abcde});
    rd(ADDR_RES, {22'h2abcde, 10'h0});
    s = a + 32'h1;
    issue(alu_w(5'h8, 1'b1, OP_TAG_ADD, 5'h1, 1'b1, 13'h1));
    rd(ADDR_STAT, {28'h0, s[31], s == 32'h0, 1'b1, s < a});
    issue(alu_w(5'h8, 1'b1, OP_TAG_ADD_TRAP, 5'h1, 1'b1, 13'h1));
    rd(ADDR_STAT, {16'h0, TT_TAG_OVF, 4'h1, s[31], s == 32'h0, 1'b1, s < a});
    chk_trap(1'b1);
    xfer(1'b1, ADDR_STAT, 32'h14);
    chk_trap(1'b0);
    issue({FMT_CTL, 5'h1, 1'b0, OP_COND_TRAP, 5'h0, 1'b1, 13'h5});
    rd(ADDR_STAT, {16'h0, 8'h85, 8'h14});
    xfer(1'b1, ADDR_STAT, 32'h14);
    setr(5'ha, 32'h0);
    xfer(1'b1, ADDR_PC, 32'h100);
    issue({FMT_BRANCH, 1'b1, 4'h1, 1'b0, BK_INT, 22'h3});
    rd(ADDR_NPC, 32'h110);
    issue(alu_w(5'ha, 1'b0, OP_ADD, 5'h0, 1'b1, 13'h55));
    rd(ADDR_RDAT, 32'h55);
    rd(ADDR_PC, 32'h110);
    xfer(1'b1, ADDR_PC, 32'h200);
    issue({FMT_BRANCH, 1'b1, 4'h0, 1'b0, BK_INT, 22'h3});
    issue(alu_w(5'ha, 1'b0, OP_ADD, 5'h0, 1'b1, 13'h66));
    rd(ADDR_RDAT, 32'h55);
    rd(ADDR_PC, 32'h208);
    xfer(1'b1, ADDR_PC, 32'h400);
    issue({FMT_CTL, 5'hb, 1'b0, OP_JUMP_LINK, 5'h1, 1'b1, 13'h0010});
    rd(ADDR_NPC, a + 32'h10);
    issue({FMT_CTL, 5'hc, 1'b0, OP_WIN_SAVE, 5'h1, 1'b1, 13'h0008});
    rd(ADDR_RES, a + 32'h8);
    issue({FMT_CTL, 5'h0, 1'b0, OP_TRAP_RETURN, 5'h1, 1'b1, 13'h0020});
    rd(ADDR_NPC, a + 32'h20);
    for (int k = 0; k < 4; k++)
    begin
      xfer(1'b1, ADDR_PC, 32'h300);
      fval <= (k == 3) ? 2'h2 : {1'b0, k[1]};
      lat <= {1'b0, k[1:0], 1'b0};
      fld <= 1'b1;
      @(posedge clk);
      fld <= 1'b0;
      issue({FMT_BRANCH, 1'b0, k[1] ? 4'h4 : (k[0] ? 4'h1 : 4'h9), 1'b0,
        k[1] ? BK_COPROC : BK_FLOAT, 22'h2});
      rd(ADDR_NPC, k[0] ? 32'h308 : 32'h30c);
    end
    wrap_up();
  end
endmodule : iab_alu_branch_unit_bench
`default_nettype wire
